// ===== dv/adc_conversion_sequencer_tb_top.sv
// testbench: apb master, start pin and dma partner around the sequencer
// assumes the partner model and the bound checker are compiled first
module adc_conversion_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr, soc = 0;
  logic ack_en = 0, ack, mod_en, dec_rst, eoc, drq, irq;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] val = 0, dd, res;
  int n_fail = 0, compares = 0, c;
  logic [2:0] mux;
  // conversion period used by every test, in mclk cycles
  localparam int PER = 4;
  always #2.5 clk = ~clk;
  adc_conversion_sequencer adc_conversion_sequencer_i (.mclk_i(clk), .rst_n_i(rst_n),
    .ce_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .soc_i(soc), .dec_data_i(dd), .dma_ack_i(ack), .mod_en_o(mod_en),
    .dec_rst_o(dec_rst), .mux_sel_o(mux), .result_o(res), .eoc_o(eoc), .drq_o(drq),
    .irq_o(irq));
  dma_partner dma_partner_i (.mclk_i(clk), .rst_n_i(rst_n), .drq_i(drq), .en_i(ack_en),
    .val_i(val), .dec_data_o(dd), .dma_ack_o(ack));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request is held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1)
      n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(0, a, 0, r, e);
    chk(r, x);
  endtask
  // cycles up to the next rising edge of eoc, bounded
  task rise(output int n);
    logic p;
    n = 0;
    do
    begin
      p = eoc;
      @(posedge clk);
      n++;
    end while (!(eoc === 1'b1 && p === 1'b0) && n < 300);
  endtask
  task t_single;
    logic [31:0] r;
    logic e;
    rd(8'h04, 32'h40);
    apb(0, 8'h1C, 0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(8'h04, PER);
    wr(8'h0C, 32'h1);
    val <= 16'h5A3C;
    repeat (10) @(posedge clk);
    chk(mod_en, 0);
    wr(8'h00, 32'h1);
    rise(c);
    // four conversion periods, eoc registered once more, seen one edge later
    chk(c, 4 * PER + 2);
    chk(res, 16'h5A3C);
    chk(irq, 1);
    repeat (8) @(posedge clk);
    chk(eoc, 1);
    rd(8'h08, 32'h1);
    rd(8'h14, 32'h5A3C);
    repeat (2) @(posedge clk);
    chk({eoc, mod_en}, 0);
    wr(8'h10, 32'h1);
    @(posedge clk);
    chk(irq, 0);
    $display("single done");
  endtask
  task t_soc;
    wr(8'h00, 32'h10);
    ack_en <= 1;
    val <= 16'hC3A5;
    soc <= 1;
    repeat (4) @(posedge clk);
    soc <= 0;
    rise(c);
    // the pin start lands three edges after soc rises, one before rise begins
    chk(c, 4 * PER + 1);
    chk({drq, res}, 17'h1C3A5);
    rise(c);
    chk(c, 300);
    chk(mod_en, 0);
    $display("soc done");
  endtask
  task t_cont;
    // one input throughout: the mux field is left alone while this runs
    wr(8'h00, 32'h15);
    rise(c);
    chk(c, 4 * PER + 2);
    rise(c);
    chk(c, PER);
    // start while busy, asking for single mode: neither may take effect
    wr(8'h00, 32'h11);
    rise(c);
    chk(c, PER);
    rise(c);
    chk(c, PER);
    chk(eoc, 1);
    wr(8'h00, 32'h2);
    repeat (3) @(posedge clk);
    chk(mod_en, 0);
    rd(8'h00, 32'h4);
    $display("cont done");
  endtask
  task t_multi;
    wr(8'h00, 32'h19);
    rise(c);
    chk(c, 4 * PER + 2);
    rise(c);
    // the next sample starts by itself and is fully re-primed
    chk(c, 4 * PER + 1);
    // a new input selection re-primes from the write edge onwards
    wr(8'h00, 32'h38);
    rise(c);
    chk(c, 4 * PER + 2);
    chk(mux, 3'h1);
    wr(8'h00, 32'h2);
    $display("multi done");
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    #100000;
    n_fail++;
    summarize;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_single;
    t_soc;
    t_cont;
    t_multi;
    summarize;
  end
endmodule // adc_conversion_sequencer_tb_top

// ===== dv/adc_seq_properties.sv
// checker: apb timing and conversion handshake of the sequencer
// assumes ce_i is held high; bound to the top module below
`include "adc_seq_defines.vh"
module adc_seq_chk (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // converter side
  input wire logic dma_ack_i,
  input wire logic mod_en_o,
  input wire logic dec_rst_o,
  input wire logic eoc_o,
  input wire logic drq_o,
  input wire logic [2:0] mux_sel_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // a completed read of the result word is one of the two ways eoc may drop
  wire logic rd_res = psel_i && penable_i && pready_o && !pwrite_i && paddr_i == `REG_RESULT;
  // priming: no result can appear for at least three cycles after a reset
  sequence prime_s;
    (!$rose(eoc_o)) [*3];
  endsequence
  chk_pready_once: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  chk_one_wait: assert property (psel_i && $rose(penable_i) |=> pready_o)
    else $error("no answer after one wait state");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_eoc_hold: assert property (eoc_o && !dma_ack_i && !rd_res |=> eoc_o)
    else $error("eoc dropped before read");
  chk_drq_eoc: assert property (drq_o |-> eoc_o)
    else $error("dma request without eoc");
  chk_rst_pulse: assert property (dec_rst_o |=> !dec_rst_o)
    else $error("decimator reset longer than one cycle");
  chk_eoc_run: assert property ($rose(eoc_o) |-> $past(mod_en_o))
    else $error("result while converter idle");
  chk_start_prime: assert property ($rose(mod_en_o) |-> dec_rst_o ##1 prime_s)
    else $error("start without decimator reset");
  chk_reprime_gap: assert property (dec_rst_o |=> prime_s)
    else $error("result too soon after reset");
  // a new input selection while running must restart the decimator at once
  chk_mux_reprime: assert property ($changed(mux_sel_o) && $past(mod_en_o) && mod_en_o |-> dec_rst_o)
    else $error("input switched without re-priming");
endmodule // adc_seq_chk

bind adc_conversion_sequencer adc_seq_chk adc_seq_chk_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .dma_ack_i(dma_ack_i), .mod_en_o(mod_en_o), .dec_rst_o(dec_rst_o), .eoc_o(eoc_o),
  .drq_o(drq_o), .mux_sel_o(mux_sel_o));

// ===== dv/dma_partner.sv
// partner: decimator data source and dma controller taking results
// assumes drq_o is a registered level on mclk_i
module dma_partner (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic drq_i,
  input wire logic en_i,
  input wire logic [15:0] val_i,
  output logic [15:0] dec_data_o,
  output logic dma_ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] w_q;
  assign dec_data_o = val_i;
  // acknowledge after two stall cycles; a stalled dma must not lose results
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      w_q <= 2'h0;
      dma_ack_o <= 1'b0;
    end
    else
    begin
      w_q <= (drq_i && !dma_ack_o) ? w_q + 2'h1 : 2'h0;
      dma_ack_o <= en_i && drq_i && w_q == 2'h1;
    end
  end
endmodule // dma_partner

// ===== hw/adc_conversion_sequencer.v
// adc conversion sequencer: start, decimator priming, result and done handling
// assumes dec_data_i and dma_ack_i come from logic on mclk_i; soc_i is a pin
//
// Local design decisions: the APB slave port and the placing of the registers.
`include "adc_seq_defines.vh"
module adc_conversion_sequencer
#(
  parameter RES_W = 16,
  parameter PER_W = 16
)
(
  // clock, reset, clock enable
  input wire mclk_i,
  input wire rst_n_i,
  input wire ce_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // start strobe pin and decimator / dma side
  input wire soc_i,
  input wire [RES_W-1:0] dec_data_i,
  input wire dma_ack_i,
  // converter control and completion
  output reg mod_en_o,
  output reg dec_rst_o,
  output reg [2:0] mux_sel_o,
  output reg [RES_W-1:0] result_o,
  output reg eoc_o,
  output reg drq_o,
  output reg irq_o
);

  // one-hot sequencer states
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_PRIME = 4'b0010;
  localparam [3:0] S_RUN = 4'b0100;
  localparam [3:0] S_WAIT = 4'b1000;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [2:0] prime_q;
  reg [2:0] prime_d;
  reg [1:0] mode_q;
  reg dma_en_q;
  reg [PER_W-1:0] period_q;
  reg [`ST_W-1:0] status_q;
  reg [`ST_W-1:0] status_d;
  reg [`ST_W-1:0] int_en_q;
  reg soc_prev_q;
  reg restart;
  reg yield;
  reg eoc_d;

  wire soc_s;
  wire soc_rise;
  wire conv_end;
  wire acc;
  wire wr_acc;
  wire rd_acc;
  wire sw_start;
  wire sw_stop;
  wire mux_chg;
  wire rd_result;
  wire start_req;

  // the start pin is asynchronous, so it is synchronised before edge detection
  sync2 u_soc_sync
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(soc_i),
    .q_o(soc_s)
  );

  // conversion time base; restarted when the converter is reset
  conv_timer #(.CNT_W(PER_W)) u_timer
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(state_q[1] | state_q[2]),
    .restart_i(restart),
    .period_i(period_q),
    .conv_end_o(conv_end)
  );

  // apb access completes at the edge where pready is seen high
  assign acc = psel_i & penable_i & pready_o;
  assign wr_acc = acc & pwrite_i;
  assign rd_acc = acc & ~pwrite_i;
  assign sw_start = wr_acc && (paddr_i == `REG_CTRL) && pwdata_i[`CTRL_START];
  assign sw_stop = wr_acc && (paddr_i == `REG_CTRL) && pwdata_i[`CTRL_STOP];
  assign mux_chg = wr_acc && (paddr_i == `REG_CTRL) &&
                   (pwdata_i[`CTRL_MUX_HI:`CTRL_MUX_LO] != mux_sel_o);
  assign rd_result = rd_acc && (paddr_i == `REG_RESULT);

  // strobe edge; a tied-low pin simply never starts anything
  assign soc_rise = soc_s & ~soc_prev_q;
  assign start_req = sw_start | soc_rise;

  // sequencer next state
  always @*
  begin
    state_d = state_q;
    prime_d = prime_q;
    restart = 1'b0;
    yield = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        // standby: nothing converts until a start arrives
        if (start_req && !sw_stop)
        begin
          state_d = S_PRIME;
          prime_d = 3'h0;
          restart = 1'b1;
        end
      end
      S_PRIME:
      begin
        if (conv_end)
        begin
          if (prime_q == `PRIME_LAST)
          begin
            yield = 1'b1;
            prime_d = 3'h0;
            if (mode_q == `MODE_CONT)
              state_d = S_RUN;
            else if (mode_q == `MODE_MULTI)
            begin
              restart = 1'b1;
              state_d = S_PRIME;
            end
            else
              state_d = S_WAIT;
          end
          else
            prime_d = prime_q + 3'h1;
        end
      end
      S_RUN:
      begin
        // primed pipeline: every conversion now yields a result
        if (conv_end)
          yield = 1'b1;
      end
      S_WAIT:
      begin
        // single result waits for its transfer, then standby again
        if (!eoc_o)
          state_d = S_IDLE;
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
    // a new input needs four fresh samples before anything is valid
    if (mux_chg && (state_q[1] || state_q[2]))
    begin
      state_d = S_PRIME;
      prime_d = 3'h0;
      restart = 1'b1;
      yield = 1'b0;
    end
    if (sw_stop)
    begin
      state_d = S_IDLE;
      prime_d = 3'h0;
      yield = 1'b0;
    end
  end

  // done flag and sticky status; a new event wins over a clear
  always @*
  begin
    eoc_d = eoc_o;
    if (rd_result || dma_ack_i)
      eoc_d = 1'b0;
    if (yield)
      eoc_d = 1'b1;
    status_d = status_q;
    if (wr_acc && (paddr_i == `REG_INT_CLR))
      status_d = status_q & ~pwdata_i[`ST_W-1:0];
    if (yield)
      status_d[`ST_DONE] = 1'b1;
    if (yield && eoc_o && !(rd_result || dma_ack_i))
      status_d[`ST_OVERRUN] = 1'b1;
  end

  // sequencer, result and completion outputs
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= S_IDLE;
      prime_q <= 3'h0;
      soc_prev_q <= 1'b0;
      status_q <= {`ST_W{1'b0}};
      result_o <= {RES_W{1'b0}};
      eoc_o <= 1'b0;
      drq_o <= 1'b0;
      irq_o <= 1'b0;
      mod_en_o <= 1'b0;
      dec_rst_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      prime_q <= prime_d;
      soc_prev_q <= soc_s;
      status_q <= status_d;
      if (yield)
        result_o <= dec_data_i;
      eoc_o <= eoc_d;
      // host picks polling, interrupt or dma by the enables
      drq_o <= eoc_d & dma_en_q;
      irq_o <= |(status_d & int_en_q);
      mod_en_o <= state_d[1] | state_d[2];
      dec_rst_o <= restart;
    end
  end

  // register writes; mode only changes from standby
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= `MODE_RST;
      dma_en_q <= 1'b0;
      mux_sel_o <= `MUX_RST;
      period_q <= `PERIOD_RST;
      int_en_q <= {`ST_W{1'b0}};
    end
    else if (ce_i && wr_acc)
    begin
      if (paddr_i == `REG_CTRL)
      begin
        if (state_q == S_IDLE)
          mode_q <= pwdata_i[`CTRL_MODE_HI:`CTRL_MODE_LO];
        dma_en_q <= pwdata_i[`CTRL_DMA_EN];
        mux_sel_o <= pwdata_i[`CTRL_MUX_HI:`CTRL_MUX_LO];
      end
      else if (paddr_i == `REG_PERIOD)
        period_q <= pwdata_i[PER_W-1:0];
      else if (paddr_i == `REG_INT_EN)
        int_en_q <= pwdata_i[`ST_W-1:0];
    end
  end

  // apb answer: one wait state, read data loaded with pready
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      if (psel_i && penable_i && !pready_o)
      begin
        pready_o <= 1'b1;
        pslverr_o <= 1'b0;
        prdata_o <= 32'h00000000;
        if (paddr_i == `REG_CTRL)
        begin
          prdata_o[`CTRL_MODE_HI:`CTRL_MODE_LO] <= mode_q;
          prdata_o[`CTRL_DMA_EN] <= dma_en_q;
          prdata_o[`CTRL_MUX_HI:`CTRL_MUX_LO] <= mux_sel_o;
        end
        else if (paddr_i == `REG_PERIOD)
          prdata_o[PER_W-1:0] <= period_q;
        else if (paddr_i == `REG_STATUS)
          prdata_o[`ST_W-1:0] <= status_q;
        else if (paddr_i == `REG_INT_EN)
          prdata_o[`ST_W-1:0] <= int_en_q;
        else if (paddr_i == `REG_INT_CLR)
          prdata_o <= 32'h00000000; // write-only, reads zero
        else if (paddr_i == `REG_RESULT)
          prdata_o[RES_W-1:0] <= result_o;
        else if (paddr_i == `REG_STATE)
        begin
          prdata_o[0] <= eoc_o;
          prdata_o[4:1] <= state_q;
          prdata_o[7:5] <= prime_q;
        end
        else
          pslverr_o <= 1'b1;
      end
      else
      begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

endmodule // adc_conversion_sequencer

// ===== hw/adc_seq_defines.vh
// constants for the adc conversion sequencer: register map, fields, resets
// assumes a 32-bit apb slave at byte addresses, one word per register
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_PERIOD 8'h04
`define REG_STATUS 8'h08
`define REG_INT_EN 8'h0C
`define REG_INT_CLR 8'h10
`define REG_RESULT 8'h14
`define REG_STATE 8'h18

// control register fields
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 3
`define CTRL_DMA_EN 4
`define CTRL_MUX_LO 5
`define CTRL_MUX_HI 7

// operating modes
`define MODE_SINGLE 2'h0
`define MODE_CONT 2'h1
`define MODE_MULTI 2'h2

// status / interrupt bits
`define ST_DONE 0
`define ST_OVERRUN 1
`define ST_W 2

// reset values
`define PERIOD_RST 16'h0040
`define MODE_RST 2'h0
`define MUX_RST 3'h0

// conversions per result: three priming plus the one that yields
`define PRIME_LAST 3'h3

`endif

// ===== hw/conv_timer.v
// conversion period timer: one pulse per elapsed conversion time
// assumes run_i and restart_i come from logic on mclk_i
module conv_timer
#(
  parameter CNT_W = 16
)
(
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  input wire ce_i,
  // control
  input wire run_i,
  input wire restart_i,
  input wire [CNT_W-1:0] period_i,
  // one-cycle pulse at end of each conversion
  output reg conv_end_o
);

  reg [CNT_W-1:0] cnt_q;
  wire [CNT_W-1:0] last;

  // a period of zero behaves as one cycle so the timer never stalls
  assign last = (period_i == {CNT_W{1'b0}}) ? {CNT_W{1'b0}} : period_i - 1'b1;

  // restart drops any partial conversion, as the decimator is reset too
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= {CNT_W{1'b0}};
      conv_end_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (restart_i || !run_i)
      begin
        cnt_q <= {CNT_W{1'b0}};
        conv_end_o <= 1'b0;
      end
      else if (cnt_q >= last)
      begin
        cnt_q <= {CNT_W{1'b0}};
        conv_end_o <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + 1'b1;
        conv_end_o <= 1'b0;
      end
    end
  end

endmodule // conv_timer

// ===== hw/sync2.v
// two-flop synchroniser for a level arriving from outside the clock domain
// assumes the input is a level held for at least two mclk_i periods
module sync2
(
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  input wire ce_i,
  // asynchronous level in, synchronised level out
  input wire d_i,
  output wire q_o
);

  reg meta_q;
  reg sync_q;

  // first flop is read only by the second one
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule // sync2
